// ===== testbench/asat_sram_model.sv
// asat_sram_model: behavioural byte-wide static memory at the far side of asat_ctrl.
// resolves the shared data wires itself from host_data and host_oe; the bench feeds bus back to the host.
`timescale 1ns/1ps
module asat_sram_model #(
  parameter int AW = 17,
  parameter int ACC_NS = 10,
  parameter int HOLD_NS = 3
) (
  input wire logic [AW-1:0] sram_addr,
  input wire logic select_low_active_n,
  input wire logic select_high_active,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  output logic [7:0] bus
);
  logic [7:0] mem [int];
  logic wr_q = 1'b0;
  logic late = 1'b0;
  logic [7:0] junk = 8'h3c;
  logic [AW-1:0] rd_addr;
  logic sel, wr, rd;
  // mode decode from selects, enable and strobe
  assign sel = !select_low_active_n && select_high_active;
  assign wr = sel && !write_strobe_n;
  assign rd = sel && !output_enable_n && write_strobe_n;
  // store at the first edge that breaks the overlap
  always @(wr) begin
    if (wr_q === 1'b1 && wr === 1'b0) begin
      mem[sram_addr] = host_data;
    end
    wr_q = wr;
  end
  // old byte held a while, then unknown, new byte one access time on
  always @(rd, sram_addr) begin
    rd_addr <= #(HOLD_NS) sram_addr;
    late <= #(HOLD_NS) 1'b0;
    late <= #(ACC_NS) (rd === 1'b1);
  end
  // released wires wander rather than keep a value
  always #7 junk = ~junk;
  // drive only while reading, float at once otherwise
  always @* begin
    if (host_oe && rd) begin
      bus = 8'hxx;
    end else if (host_oe) begin
      bus = host_data;
    end else if (rd && late) begin
      bus = mem.exists(rd_addr) ? mem[rd_addr] : ~rd_addr[7:0];
    end else begin
      bus = junk;
    end
  end
endmodule : asat_sram_model

// ===== testbench/tb_async_sram_access_timing.sv
// tb_async_sram_access_timing: random and corner accesses through asat_ctrl to a memory model.
// assumes asat_pkg and the design files are compiled first.
`timescale 1ns/1ps
module tb_async_sram_access_timing;
  import asat_pkg::*;
  localparam int PW = 8;
  localparam int AW = ADDR_W;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic retention_req = 1'b0;
  logic [AW-1:0] req_addr = '0;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, power_ok, retention_ok, sel_n, sel_h, oe_n, we_n, data_oe;
  logic last_sel = 1'b0;
  logic [7:0] rsp_rdata, data_o, bus;
  logic [AW-1:0] sram_addr, last_addr;
  logic [7:0] shadow [int];
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  asat_ctrl #(.PWRUP_CYC(PW)) dut (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .power_ok(power_ok),
    .retention_req(retention_req), .retention_ok(retention_ok), .sram_addr(sram_addr),
    .select_low_active_n(sel_n), .select_high_active(sel_h), .output_enable_n(oe_n),
    .write_strobe_n(we_n), .sram_data_o(data_o), .sram_data_oe(data_oe), .sram_data_i(bus));
  asat_sram_model #(.AW(AW), .ACC_NS(10)) mem_model (.sram_addr(sram_addr),
    .select_low_active_n(sel_n), .select_high_active(sel_h), .output_enable_n(oe_n),
    .write_strobe_n(we_n), .host_data(data_o), .host_oe(data_oe), .bus(bus));

  initial forever #10 sys_clk = ~sys_clk;

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  function automatic logic [7:0] expect_rd(input logic [AW-1:0] a);
    return shadow.exists(a) ? shadow[a] : ~a[7:0];
  endfunction : expect_rd

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // one request held until taken; reads wait for the answer
  task automatic access(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
    int k;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge sys_clk);
      k++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    if (w) begin
      shadow[a] = d;
      @(negedge sys_clk); // an edge passes before valid may rise again
    end else begin
      k = 0;
      while (rsp_valid !== 1'b1 && k < 8) begin
        @(negedge sys_clk);
        k++;
      end
      chk_bit(rsp_valid, 1'b1);
      chk_byte(rsp_rdata, expect_rd(a));
    end
  endtask : access

  // pin watch every cycle, plus the run limit
  always @(negedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      finish_test();
    end
    if (!reset) begin
      chk_bit(sel_h, ~sel_n);
      if (!oe_n) chk_bit(data_oe, 1'b0);
      if (!we_n) chk_bit(data_oe, 1'b1);
      if (!we_n) chk_bit(oe_n, 1'b1);
      if (!power_ok) chk_bit(req_ready, 1'b0);
      if (!sel_n && last_sel) chk_bit(sram_addr == last_addr, 1'b1);
    end
    last_addr = sram_addr;
    last_sel = !sel_n;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n = $urandom(97947);
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    n = 0;
    while (power_ok !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit(n == PW, 1'b1);
    // corners: both ends of the address range, back to back, unwritten place
    access(1'b1, '1, 8'h81);
    access(1'b1, '0, 8'h7e);
    access(1'b0, '1, 8'h00);
    access(1'b0, '0, 8'h00);
    access(1'b0, 17'h00005, 8'h00);
    repeat (60) access(1'($urandom), AW'($urandom_range(31, 0)), 8'($urandom));
    // retention blocks new requests while idle and deselected
    retention_req = 1'b1;
    req_write = 1'b0;
    req_addr = '1;
    req_valid = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_bit(req_ready, 1'b0);
    chk_bit(retention_ok, 1'b1);
    chk_bit(sel_n, 1'b1);
    // the held read is taken once retention is dropped
    retention_req = 1'b0;
    @(negedge sys_clk);
    chk_bit(sel_n, 1'b0);
    access(1'b0, '1, 8'h00);
    finish_test();
  end
endmodule : tb_async_sram_access_timing

// ===== verilog/asat_ctrl.sv
// asat_ctrl: host-side sequencer for an asynchronous byte-wide static memory.
// assumes one 50 MHz clock, a memory with no clock, and that the board resolves the
// shared data wires from sram_data_oe and the memory's own output drivers.
//
// Behaviour
// - setup and hold are counted from the edge ending the write.
// - write data stands stable at least 6 ns before write end.
// - write data may change at the write-ending edge; hold is 0 ns.
// - address stands stable at least 7 ns before write end.
// - address is valid no later than the start of the write overlap.
// - address held up to the write-ending edge.
// - strobe pulse covers float delay plus data setup.
// - first access waits at least 100 us after power is up.
// - retention may be entered as soon as the memory is deselected.
// - host never drives data while the memory drives it.
// - read address valid before or with the select assertion.
`timescale 1ns/1ps
module asat_ctrl
  import asat_pkg::*;
#(
  parameter int AW = asat_pkg::ADDR_W,
  parameter int DW = asat_pkg::DATA_W,
  parameter int PWRUP_CYC = asat_pkg::POWER_UP_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  output logic power_ok,
  input wire logic retention_req,
  output logic retention_ok,
  output logic [AW-1:0] sram_addr,
  output logic select_low_active_n,
  output logic select_high_active,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic [DW-1:0] sram_data_o,
  output logic sram_data_oe,
  input wire logic [DW-1:0] sram_data_i
);

  import asat_pkg::*;

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    asat_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic sel;
    logic oe_n;
    logic we_n;
    logic data_oe;
    logic rsp;
  } asat_state_t;

  localparam asat_state_t RESET_STATE = '{st: ST_PWRUP, cnt: '0, addr: '0, wdata: '0,
                                          rdata: '0, sel: 1'b0, oe_n: 1'b1, we_n: 1'b1,
                                          data_oe: 1'b0, rsp: 1'b0};
  localparam logic [CNT_W-1:0] PWRUP_LAST = CNT_W'(PWRUP_CYC - 1);
  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  asat_state_t q;
  asat_state_t d;
  logic [DW-1:0] data_sync;

  // read data pins pass two stages before use
  asat_sync2 #(.W(DW), .STAGES(SYNC_STAGES)) u_rd_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(sram_data_i),
    .dout(data_sync)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rsp = 1'b0;
    case (q.st)
      ST_PWRUP: begin
        if (q.cnt == PWRUP_LAST) begin
          d.st = ST_IDLE;
          d.cnt = '0;
        end else begin
          d.cnt = q.cnt + CNT_ONE;
        end
      end
      ST_IDLE: begin
        if (req_valid && !retention_req) begin
          // address and selects change on the same edge
          d.addr = req_addr;
          d.sel = 1'b1;
          d.cnt = '0;
          if (req_write) begin
            d.wdata = req_wdata;
            d.data_oe = 1'b1; // output enable stays high, bus is ours
            d.st = ST_WSET;
          end else begin
            d.oe_n = 1'b0;
            d.st = ST_RD;
          end
        end
      end
      ST_WSET: begin
        // address already stable before the overlap opens
        d.we_n = 1'b0;
        d.st = ST_WPUL;
      end
      ST_WPUL: begin
        if (q.cnt == WR_LAST) begin
          d.we_n = 1'b1; // strobe edge ends the write
          d.st = ST_WEND;
        end else begin
          d.cnt = q.cnt + CNT_ONE;
        end
      end
      ST_WEND: begin
        // data and selects released only after the strobe rose
        d.sel = 1'b0;
        d.data_oe = 1'b0;
        d.st = ST_IDLE;
      end
      ST_RD: begin
        if (q.cnt == RD_LAST) begin
          d.rdata = data_sync;
          d.rsp = 1'b1;
          d.sel = 1'b0;
          d.oe_n = 1'b1;
          d.st = ST_IDLE;
        end else begin
          d.cnt = q.cnt + CNT_ONE;
        end
      end
      default: begin
        d = RESET_STATE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready = (q.st == ST_IDLE) && !retention_req;
  assign rsp_valid = q.rsp;
  assign rsp_rdata = q.rdata;
  assign power_ok = (q.st != ST_PWRUP);
  assign retention_ok = (q.st == ST_IDLE) && !q.sel; // deselected, no wait
  assign sram_addr = q.addr;
  assign select_low_active_n = ~q.sel;
  assign select_high_active = q.sel;
  assign output_enable_n = q.oe_n;
  assign write_strobe_n = q.we_n;
  assign sram_data_o = q.wdata;
  assign sram_data_oe = q.data_oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic [CNT_W-1:0] up_cnt_q;
  logic [CNT_W-1:0] low_cnt_q;

  // cycles since reset, saturating; strobe-low length
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      up_cnt_q <= '0;
      low_cnt_q <= '0;
    end else begin
      if (up_cnt_q != '1) begin
        up_cnt_q <= up_cnt_q + CNT_ONE;
      end
      low_cnt_q <= write_strobe_n ? '0 : low_cnt_q + CNT_ONE;
    end
  end

  sequence write_open_s;
    $fell(write_strobe_n) && select_high_active && !select_low_active_n;
  endsequence

  sequence write_close_s;
    $rose(write_strobe_n);
  endsequence

  write_start_a: assert property (write_open_s |-> $stable(sram_addr) && sram_data_oe)
    else $error("address or data not set before write start");
  data_setup_a: assert property (write_close_s |-> $stable(sram_data_o) && sram_data_oe)
    else $error("write data changed before write end");
  addr_setup_a: assert property (write_close_s |-> $stable(sram_addr) && select_high_active)
    else $error("address changed before write end");
  addr_hold_a: assert property (!write_strobe_n |=> $stable(sram_addr))
    else $error("address moved during write overlap");
  strobe_end_a: assert property (write_open_s |=> write_strobe_n && select_high_active
                                 ##1 !select_high_active && !sram_data_oe)
    else $error("write not ended by strobe before deselect");
  pulse_len_a: assert property (write_close_s |-> low_cnt_q == WR_LAST + CNT_ONE)
    else $error("strobe pulse length wrong");
  bus_float_a: assert property (sram_data_oe |-> output_enable_n)
    else $error("host drives data while output enable low");
  read_addr_a: assert property (select_high_active && $past(select_high_active)
                                |-> $stable(sram_addr))
    else $error("address changed while selected");
  power_wait_a: assert property (select_high_active |-> up_cnt_q > PWRUP_LAST)
    else $error("access before power-up wait");
  retention_a: assert property (retention_ok |-> select_low_active_n && !select_high_active)
    else $error("retention allowed while selected");
  read_time_a: assert property ($fell(output_enable_n) |-> !output_enable_n[*3]
                                ##1 output_enable_n && rsp_valid)
    else $error("read cycle length wrong");

endmodule : asat_ctrl

// ===== verilog/asat_pkg.sv
// asat_pkg: constants for the asynchronous static memory access controller.
// assumes a single 50 MHz system clock; all pin timing is counted in its cycles.
package asat_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // clock and pin timing, in the units printed
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDRESS_ACCESS_DELAY_NS = 10;
  localparam int READ_DATA_HOLD_AFTER_ADDRESS_NS = 3;
  localparam int OUTPUT_ENABLE_ACCESS_DELAY_NS = 5;
  localparam int WRITE_DATA_SETUP_NS = 6;
  localparam int WRITE_DATA_HOLD_NS = 0;
  localparam int ADDRESS_SETUP_TO_WRITE_END_NS = 7;
  localparam int ADDRESS_SETUP_TO_WRITE_START_NS = 0;
  localparam int ADDRESS_HOLD_AFTER_WRITE_NS = 0;
  localparam int STROBE_LOW_TO_FLOAT_NS = 5;
  localparam int POWER_UP_WAIT_US = 100;
  localparam int DESELECT_TO_RETENTION_NS = 0;

  // least time to whole cycles, never below one
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  localparam int WR_PULSE_CYC = max2(max2(ceil_cyc(WRITE_DATA_SETUP_NS),
                                          ceil_cyc(ADDRESS_SETUP_TO_WRITE_END_NS)),
                                     ceil_cyc(STROBE_LOW_TO_FLOAT_NS + WRITE_DATA_SETUP_NS));
  localparam int ACCESS_CYC = max2(ceil_cyc(ADDRESS_ACCESS_DELAY_NS),
                                   ceil_cyc(OUTPUT_ENABLE_ACCESS_DELAY_NS));
  localparam int RD_CYC = ACCESS_CYC + SYNC_STAGES;
  localparam int POWER_UP_WAIT_CYC = ceil_cyc(POWER_UP_WAIT_US * 1000);

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_PWRUP = 6'h01,
    ST_IDLE  = 6'h02,
    ST_WSET  = 6'h04,
    ST_WPUL  = 6'h08,
    ST_WEND  = 6'h10,
    ST_RD    = 6'h20
  } asat_st_t;

endpackage : asat_pkg

// ===== verilog/asat_sync2.sv
// asat_sync2: plain multi-stage synchroniser for pin inputs.
// assumes the input is asynchronous to sys_clk; only the last stage is read.
`timescale 1ns/1ps
module asat_sync2 #(
  parameter int W = 8,
  parameter int STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage_q [STAGES];

  // ----------------------------------------------------------------
  // shift chain
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= din;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign dout = stage_q[STAGES-1];

endmodule : asat_sync2
